// [ebms_pkg.sv]
// Constants for the energy bucket, min/max, sag and alarm block
package ebms_pkg;
  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int W         = 24;
  localparam int BKT_W     = 48;
  localparam int SLOTS     = 8;
  localparam int SLOT_W    = 3;
  localparam int PHASES    = 3;
  localparam int AW        = 8;
  localparam int SQ_W      = 50;
  localparam int SAG_AW    = 74;
  localparam int SIGN_DLY  = 2;
  // ----------------------------------------------------------------
  // Word addresses
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_BKT_H   = 8'h01;
  localparam logic [AW-1:0] A_BKT_L   = 8'h02;
  localparam logic [AW-1:0] A_CMD     = 8'h03;
  localparam logic [AW-1:0] A_CFG     = 8'h04;
  localparam logic [AW-1:0] A_STAT    = 8'h05;
  localparam logic [AW-1:0] A_STICKY  = 8'h06;
  localparam logic [AW-1:0] A_SCLR    = 8'h07;
  localparam logic [AW-1:0] A_MASK    = 8'h08;
  localparam logic [AW-1:0] A_SAG_CNT = 8'h09;
  localparam logic [AW-1:0] A_SAG_LIM = 8'h0a;
  localparam logic [AW-1:0] A_T_MAX   = 8'h0b;
  localparam logic [AW-1:0] A_T_MIN   = 8'h0c;
  localparam logic [AW-1:0] A_F_MAX   = 8'h0d;
  localparam logic [AW-1:0] A_F_MIN   = 8'h0e;
  localparam logic [AW-1:0] A_V_MAX   = 8'h0f;
  localparam logic [AW-1:0] A_V_MIN   = 8'h10;
  localparam logic [AW-1:0] A_I_MAX   = 8'h11;
  localparam logic [AW-1:0] A_PF_LOW  = 8'h12;
  localparam logic [AW-1:0] A_ECNT    = 8'h13;
  localparam logic [AW-1:0] A_SEL0    = 8'h20;
  localparam logic [AW-1:0] A_MIN_BLK = 8'h28;
  localparam logic [AW-1:0] A_MAX_BLK = 8'h30;
  localparam int            BLK_LSB   = 3;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_CLRTRK = 0;
  localparam int CFG_SGN    = 0;
  localparam int B_SAG_A    = 4;
  localparam int B_OV_IRMS  = 7;
  localparam int B_UN_PF    = 10;
  localparam int B_UN_VRMS  = 13;
  localparam int B_UN_TEMP  = 19;
  localparam int B_OV_TEMP  = 20;
  localparam int B_UN_FREQ  = 21;
  localparam int B_OV_FREQ  = 22;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [W-1:0] RST_WORD = 24'h000000;
endpackage

// [ebms_top.sv]
// Energy bucket, min/max tracking, sag detection and alarm logic
`timescale 1ns/100ps

// Notes on behaviour
// - Bucket is unsigned 48 bits, integer word plus 24-bit fraction word.
// - Energy counter increments by one each time one bucket accumulates.
// - Min and max of up to eight selected results held over intervals.
// - Slot selector is a word address of the tracked result.
// - Selector of zero disables tracking for that slot.
// - Tracked values cleared by reset, power-down or reset-tracking bit.
// - Sag indicator sums squared sample minus squared threshold per phase.
// - Negative sag indicator sets that phase's sag status bit.
// - Sag status bits sit at positions 4, 5, 6 for phases A, B, C.
// - Masked-in sag bit drives the alarm pin low.
// - Sticky sag bit holds until host clear or reset.
// - Non-sticky sag bit clears once indicator no longer negative.
// - Three configuration bits enable sign output per phase.
// - Enabled sign pin follows phase voltage polarity two samples late.
// - Cleared sign enable returns pin to general-purpose use.
// - Sign outputs use general-purpose pin bits 6, 7, 8.
// - Low-rate alarms evaluated once every accumulation interval.
// - Temperature, frequency, voltage alarms on upper and lower limits.
// - RMS current checked only against an upper limit.
// - Power factor checked only against a lower limit, S.22 coding.
// - Thresholds share the coding of the results they are compared to.
module ebms_top (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    pwr_down,
  // Register word access
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [23:0]             reg_wdata,
  output logic      [23:0]             reg_rdata,
  // Interval timing and energy input
  input  wire logic                    interval_end,
  input  wire logic                    energy_valid,
  input  wire logic [47:0]             energy_in,
  // Low-rate results
  input  wire logic [23:0]             res_temp,
  input  wire logic [23:0]             res_freq,
  input  wire logic [2:0][23:0]        res_vrms,
  input  wire logic [2:0][23:0]        res_irms,
  input  wire logic [2:0][23:0]        res_pf,
  // Tracked result lookup
  output logic      [7:0]              trk_addr,
  input  wire logic [23:0]             trk_data,
  // High-rate samples
  input  wire logic                    sample_valid,
  input  wire logic [2:0][23:0]        sample_v,
  // General-purpose pins 6..8
  input  wire logic [2:0]              gp_out,
  input  wire logic [2:0]              gp_oe,
  output logic      [2:0]              dio_o,
  output logic      [2:0]              dio_oe,
  // Alarm pin
  output logic                         alarm_pin_n
);
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [23:0] bkt_h_reg, bkt_l_reg, cfg_reg, sticky_reg, mask_reg;
  logic [23:0] sag_cnt_reg, sag_lim_reg, t_max_reg, t_min_reg;
  logic [23:0] f_max_reg, f_min_reg, v_max_reg, v_min_reg;
  logic [23:0] i_max_reg, power_factor_lower_limit_reg;
  logic [23:0] sel_reg [ebms_pkg::SLOTS];
  logic        blk_sel, blk_min, blk_max;

  assign blk_sel = reg_addr[7:3] == ebms_pkg::A_SEL0[7:3];
  assign blk_min = reg_addr[7:3] == ebms_pkg::A_MIN_BLK[7:3];
  assign blk_max = reg_addr[7:3] == ebms_pkg::A_MAX_BLK[7:3];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bkt_h_reg   <= ebms_pkg::RST_WORD;
      bkt_l_reg   <= ebms_pkg::RST_WORD;
      cfg_reg     <= ebms_pkg::RST_WORD;
      sticky_reg  <= ebms_pkg::RST_WORD;
      mask_reg    <= ebms_pkg::RST_WORD;
      sag_cnt_reg <= ebms_pkg::RST_WORD;
      sag_lim_reg <= ebms_pkg::RST_WORD;
      t_max_reg   <= ebms_pkg::RST_WORD;
      t_min_reg   <= ebms_pkg::RST_WORD;
      f_max_reg   <= ebms_pkg::RST_WORD;
      f_min_reg   <= ebms_pkg::RST_WORD;
      v_max_reg   <= ebms_pkg::RST_WORD;
      v_min_reg   <= ebms_pkg::RST_WORD;
      i_max_reg   <= ebms_pkg::RST_WORD;
      power_factor_lower_limit_reg  <= ebms_pkg::RST_WORD;
      for (int i = 0; i < ebms_pkg::SLOTS; i++)
        sel_reg[i] <= ebms_pkg::RST_WORD;
    end
    else if (reg_wr)
    begin
      if (blk_sel)
        sel_reg[reg_addr[2:0]] <= reg_wdata;
      unique case (reg_addr)
        ebms_pkg::A_BKT_H:   bkt_h_reg   <= reg_wdata;
        ebms_pkg::A_BKT_L:   bkt_l_reg   <= reg_wdata;
        ebms_pkg::A_CFG:     cfg_reg     <= reg_wdata;
        ebms_pkg::A_STICKY:  sticky_reg  <= reg_wdata;
        ebms_pkg::A_MASK:    mask_reg    <= reg_wdata;
        ebms_pkg::A_SAG_CNT: sag_cnt_reg <= reg_wdata;
        ebms_pkg::A_SAG_LIM: sag_lim_reg <= reg_wdata;
        ebms_pkg::A_T_MAX:   t_max_reg   <= reg_wdata;
        ebms_pkg::A_T_MIN:   t_min_reg   <= reg_wdata;
        ebms_pkg::A_F_MAX:   f_max_reg   <= reg_wdata;
        ebms_pkg::A_F_MIN:   f_min_reg   <= reg_wdata;
        ebms_pkg::A_V_MAX:   v_max_reg   <= reg_wdata;
        ebms_pkg::A_V_MIN:   v_min_reg   <= reg_wdata;
        ebms_pkg::A_I_MAX:   i_max_reg   <= reg_wdata;
        ebms_pkg::A_PF_LOW:  power_factor_lower_limit_reg  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Energy bucket counting
  // ----------------------------------------------------------------
  logic [47:0] bucket, e_acc_reg;
  logic [48:0] e_sum;
  logic [23:0] ecnt_reg;

  assign bucket = {bkt_h_reg, bkt_l_reg};
  assign e_sum  = {1'b0, e_acc_reg} + {1'b0, energy_in};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      e_acc_reg <= 48'h000000000000;
      ecnt_reg  <= ebms_pkg::RST_WORD;
    end
    else if (pwr_down)
    begin
      e_acc_reg <= 48'h000000000000;
      ecnt_reg  <= ebms_pkg::RST_WORD;
    end
    else if (energy_valid)
    begin
      // Zero bucket would count on every energy_valid cycle
      if (e_sum >= {1'b0, bucket})
      begin
        e_acc_reg <= 48'(e_sum - {1'b0, bucket});
        ecnt_reg  <= ecnt_reg + 24'h000001;
      end
      else
        e_acc_reg <= e_sum[47:0];
    end
  end

  // ----------------------------------------------------------------
  // Min/max tracking scan
  // ----------------------------------------------------------------
  typedef enum logic {TRK_IDLE, TRK_SCAN} ebms_trk_e;
  ebms_trk_e   trk_state_reg;
  logic [2:0]  slot_reg, slot_q_reg;
  logic        look_q_reg, trk_clr;
  logic [23:0] min_reg [ebms_pkg::SLOTS];
  logic [23:0] max_reg [ebms_pkg::SLOTS];
  logic [7:0]  seen_reg;

  assign trk_clr = reg_wr && reg_addr == ebms_pkg::A_CMD
                   && reg_wdata[ebms_pkg::CMD_CLRTRK];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trk_state_reg <= TRK_IDLE;
      slot_reg      <= 3'h0;
      slot_q_reg    <= 3'h0;
      look_q_reg    <= 1'b0;
      trk_addr      <= 8'h00;
    end
    else
    begin
      look_q_reg <= 1'b0;
      unique case (trk_state_reg)
        TRK_IDLE:
          if (interval_end)
          begin
            trk_state_reg <= TRK_SCAN;
            slot_reg      <= 3'h0;
          end
        TRK_SCAN:
        begin
          trk_addr   <= sel_reg[slot_reg][7:0];
          slot_q_reg <= slot_reg;
          look_q_reg <= sel_reg[slot_reg] != ebms_pkg::RST_WORD;
          slot_reg   <= slot_reg + 3'h1;
          if (slot_reg == 3'(ebms_pkg::SLOTS - 1))
            trk_state_reg <= TRK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen_reg <= 8'h00;
      for (int i = 0; i < ebms_pkg::SLOTS; i++)
      begin
        min_reg[i] <= ebms_pkg::RST_WORD;
        max_reg[i] <= ebms_pkg::RST_WORD;
      end
    end
    else if (pwr_down || trk_clr)
    begin
      seen_reg <= 8'h00;
      for (int i = 0; i < ebms_pkg::SLOTS; i++)
      begin
        min_reg[i] <= ebms_pkg::RST_WORD;
        max_reg[i] <= ebms_pkg::RST_WORD;
      end
    end
    else if (look_q_reg)
    begin
      seen_reg[slot_q_reg] <= 1'b1;
      if (!seen_reg[slot_q_reg] ||
          $signed(trk_data) < $signed(min_reg[slot_q_reg]))
        min_reg[slot_q_reg] <= trk_data;
      if (!seen_reg[slot_q_reg] ||
          $signed(trk_data) > $signed(max_reg[slot_q_reg]))
        max_reg[slot_q_reg] <= trk_data;
    end
  end

  // ----------------------------------------------------------------
  // Sag detection and sign outputs
  // ----------------------------------------------------------------
  logic signed [73:0] sag_acc_reg [ebms_pkg::PHASES];
  logic        [23:0] sag_n_reg;
  logic        [2:0]  sag_cond_reg, sgn1_reg, sgn2_reg, sgn3_reg;
  logic        [47:0] lim_sq;

  assign lim_sq = sag_lim_reg * sag_lim_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sag_n_reg    <= ebms_pkg::RST_WORD;
      sag_cond_reg <= 3'h0;
      for (int p = 0; p < ebms_pkg::PHASES; p++)
        sag_acc_reg[p] <= 74'sh0;
    end
    else if (sample_valid && sag_cnt_reg != ebms_pkg::RST_WORD)
    begin
      for (int p = 0; p < ebms_pkg::PHASES; p++)
      begin
        logic signed [47:0] vsq;
        logic signed [73:0] acc_nx;
        vsq    = $signed(sample_v[p]) * $signed(sample_v[p]);
        acc_nx = sag_acc_reg[p] + 74'($signed({2'b00, vsq}))
                 - 74'($signed({2'b00, lim_sq}));
        if (sag_n_reg == sag_cnt_reg - 24'h000001)
        begin
          sag_cond_reg[p] <= acc_nx < 0;
          sag_acc_reg[p]  <= 74'sh0;
        end
        else
          sag_acc_reg[p] <= acc_nx;
      end
      if (sag_n_reg == sag_cnt_reg - 24'h000001)
        sag_n_reg <= ebms_pkg::RST_WORD;
      else
        sag_n_reg <= sag_n_reg + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sgn1_reg <= 3'h0;
      sgn2_reg <= 3'h0;
      sgn3_reg <= 3'h0;
      dio_o    <= 3'h0;
      dio_oe   <= 3'h0;
    end
    else
    begin
      if (sample_valid)
        for (int p = 0; p < ebms_pkg::PHASES; p++)
        begin
          sgn1_reg[p] <= sample_v[p][ebms_pkg::W-1];
          sgn2_reg[p] <= sgn1_reg[p];
          sgn3_reg[p] <= sgn2_reg[p];
        end
      // Pin bits 6, 7, 8 carry phases A, B, C
      for (int p = 0; p < ebms_pkg::PHASES; p++)
        dio_o[p] <= cfg_reg[ebms_pkg::CFG_SGN + p] ?
                    sgn3_reg[p] : gp_out[p];
      dio_oe <= gp_oe;
    end
  end

  // ----------------------------------------------------------------
  // Low-rate alarms and status
  // ----------------------------------------------------------------
  logic [23:0] lr_cond_reg, cond, status_reg, sclr;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lr_cond_reg <= ebms_pkg::RST_WORD;
    else if (interval_end)
    begin
      lr_cond_reg <= ebms_pkg::RST_WORD;
      lr_cond_reg[ebms_pkg::B_OV_TEMP] <=
        $signed(res_temp) > $signed(t_max_reg);
      lr_cond_reg[ebms_pkg::B_UN_TEMP] <=
        $signed(res_temp) < $signed(t_min_reg);
      lr_cond_reg[ebms_pkg::B_OV_FREQ] <= res_freq > f_max_reg;
      lr_cond_reg[ebms_pkg::B_UN_FREQ] <= res_freq < f_min_reg;
      for (int p = 0; p < ebms_pkg::PHASES; p++)
      begin
        lr_cond_reg[ebms_pkg::B_UN_VRMS + 2*p] <=
          res_vrms[p] < v_min_reg;
        lr_cond_reg[ebms_pkg::B_UN_VRMS + 2*p + 1] <=
          res_vrms[p] > v_max_reg;
        lr_cond_reg[ebms_pkg::B_OV_IRMS + p] <=
          res_irms[p] > i_max_reg;
        lr_cond_reg[ebms_pkg::B_UN_PF + p] <=
          $signed(res_pf[p]) < $signed(power_factor_lower_limit_reg);
      end
    end
  end

  always_comb
  begin
    cond = lr_cond_reg;
    cond[ebms_pkg::B_SAG_A +: ebms_pkg::PHASES] = sag_cond_reg;
  end

  assign sclr = (reg_wr && reg_addr == ebms_pkg::A_SCLR) ?
                reg_wdata : ebms_pkg::RST_WORD;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_reg  <= ebms_pkg::RST_WORD;
      alarm_pin_n <= 1'b1;
    end
    else
    begin
      // Live condition wins over a host clear
      status_reg  <= (status_reg & sticky_reg & ~sclr) | cond;
      alarm_pin_n <= ~|(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  logic [23:0] rd_next;

  always_comb
  begin
    rd_next = ebms_pkg::RST_WORD;
    if (blk_sel)
      rd_next = sel_reg[reg_addr[2:0]];
    else if (blk_min)
      rd_next = min_reg[reg_addr[2:0]];
    else if (blk_max)
      rd_next = max_reg[reg_addr[2:0]];
    else
      unique case (reg_addr)
        ebms_pkg::A_BKT_H:   rd_next = bkt_h_reg;
        ebms_pkg::A_BKT_L:   rd_next = bkt_l_reg;
        ebms_pkg::A_CFG:     rd_next = cfg_reg;
        ebms_pkg::A_STAT:    rd_next = status_reg;
        ebms_pkg::A_STICKY:  rd_next = sticky_reg;
        ebms_pkg::A_MASK:    rd_next = mask_reg;
        ebms_pkg::A_SAG_CNT: rd_next = sag_cnt_reg;
        ebms_pkg::A_SAG_LIM: rd_next = sag_lim_reg;
        ebms_pkg::A_T_MAX:   rd_next = t_max_reg;
        ebms_pkg::A_T_MIN:   rd_next = t_min_reg;
        ebms_pkg::A_F_MAX:   rd_next = f_max_reg;
        ebms_pkg::A_F_MIN:   rd_next = f_min_reg;
        ebms_pkg::A_V_MAX:   rd_next = v_max_reg;
        ebms_pkg::A_V_MIN:   rd_next = v_min_reg;
        ebms_pkg::A_I_MAX:   rd_next = i_max_reg;
        ebms_pkg::A_PF_LOW:  rd_next = power_factor_lower_limit_reg;
        ebms_pkg::A_ECNT:    rd_next = ecnt_reg;
        default:             rd_next = ebms_pkg::RST_WORD;
      endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= ebms_pkg::RST_WORD;
    else
      reg_rdata <= rd_next;
  end
endmodule // ebms_top

// [ebms_result_src.sv]
// Result source that answers the block's tracked-result lookups
`timescale 1ns/100ps
module ebms_result_src (
  // Lookup from the block
  input  wire logic [7:0]  trk_addr,
  // Result level set by the bench
  input  wire logic [23:0] res_base,
  // Answer to the block
  output logic      [23:0] trk_data
);
  // Each word address yields its own result
  assign trk_data = res_base ^ {16'h0000, trk_addr};
endmodule // ebms_result_src

// [ebms_top_sva.sv]
// Port checker for the energy, min/max, sag and alarm block
`timescale 1ns/100ps
module ebms_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register access
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  // Tracking, pins and alarm
  input wire logic        interval_end,
  input wire logic [7:0]  trk_addr,
  input wire logic [2:0]  gp_out,
  input wire logic [2:0]  gp_oe,
  input wire logic [2:0]  dio_o,
  input wire logic [2:0]  dio_oe,
  input wire logic        alarm_pin_n
);
  logic [2:0] cfg_reg;
  logic       mask_reg;
  logic [3:0] since_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Shadows of configuration writes and cycles since interval end
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) cfg_reg <= 3'h0;
    else if (reg_wr && reg_addr == ebms_pkg::A_CFG) cfg_reg <= reg_wdata[2:0];
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) mask_reg <= 1'b0;
    else if (reg_wr && reg_addr == ebms_pkg::A_MASK) mask_reg <= |reg_wdata;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) since_reg <= 4'hf;
    else if (interval_end) since_reg <= 4'h0;
    else if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_oe_follow: assert property (1'b1 |=> dio_oe == $past(gp_oe))
    else $error("pin enable not following request");
  a_reset_idle: assert property ($rose(rstn) |-> alarm_pin_n
    && dio_oe == 3'h0 && trk_addr == 8'h00)
    else $error("outputs not idle after reset");
  a_cmd_reads: assert property (reg_addr == ebms_pkg::A_CMD
    |=> reg_rdata == 24'h000000) else $error("command word reads nonzero");
  a_stat_spare: assert property (reg_addr == ebms_pkg::A_STAT
    |=> reg_rdata[3:0] == 4'h0 && !reg_rdata[23])
    else $error("status spare bits set");
  a_gp_pass: assert property (cfg_reg == 3'h0
    |=> dio_o == $past(gp_out))
    else $error("pin level not general purpose");
  a_mask_quiet: assert property (!mask_reg && !$past(mask_reg)
    |-> alarm_pin_n) else $error("alarm pin low with empty mask");
  a_trk_window: assert property ($changed(trk_addr)
    |-> since_reg <= 4'd11)
    else $error("lookup address moved outside scan");
  a_frac_back: assert property (reg_wr && reg_addr == ebms_pkg::A_BKT_L
    ##1 !reg_wr && reg_addr == ebms_pkg::A_BKT_L
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("fraction word lost");
  c_scan: cover property (interval_end ##2 trk_addr != 8'h00);
  c_alarm: cover property (!alarm_pin_n);
  c_sign: cover property (cfg_reg != 3'h0 ##1 dio_o != $past(gp_out));
endmodule // ebms_chk

bind ebms_top ebms_chk ebms_chk_i (.clk, .rstn, .reg_wr, .reg_addr,
  .reg_wdata, .reg_rdata, .interval_end, .trk_addr, .gp_out, .gp_oe,
  .dio_o, .dio_oe, .alarm_pin_n);

// [energy_bucket_minmax_sag_alarms_bench.sv]
// Self-checking bench for the energy, min/max, sag and alarm block
`timescale 1ns/100ps
module energy_bucket_minmax_sag_alarms_bench;
  localparam logic [23:0] HI = 24'h000200;
  localparam logic [23:0] LO = 24'h000080;
  logic clk, rstn, pwr_down, reg_wr, interval_end, energy_valid;
  logic sample_valid, alarm_pin_n;
  logic [7:0]       reg_addr, trk_addr;
  logic [23:0]      reg_wdata, reg_rdata, res_temp, res_freq, trk_data;
  logic [23:0]      res_base;
  logic [47:0]      energy_in;
  logic [2:0][23:0] res_vrms, res_irms, res_pf, sample_v;
  logic [2:0]       gp_out, gp_oe, dio_o, dio_oe;
  logic [23:0]      lim [8] = '{24'h001000, 24'h000400, 24'h400000,
    24'h300000, 24'h600000, 24'h100000, 24'h500000, 24'h200000};
  int               failures, samples_checked;

  ebms_top ebms_top_i (.clk, .rstn, .pwr_down, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .interval_end, .energy_valid, .energy_in,
    .res_temp, .res_freq, .res_vrms, .res_irms, .res_pf, .trk_addr,
    .trk_data, .sample_valid, .sample_v, .gp_out, .gp_oe, .dio_o,
    .dio_oe, .alarm_pin_n);
  ebms_result_src ebms_result_src_i (.trk_addr, .res_base, .trk_data);

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [23:0] exp,
                    input string what);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    check(what, reg_rdata, exp);
  endtask
  task automatic pin(input logic exp);
    repeat (2) @(negedge clk);
    check("alarm pin", {23'h0, alarm_pin_n}, {23'h0, exp});
  endtask
  task automatic ie;
    @(negedge clk);
    interval_end = 1'b1;
    @(negedge clk);
    interval_end = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  task automatic en;
    @(negedge clk);
    energy_valid = 1'b1;
    @(negedge clk);
    energy_valid = 1'b0;
  endtask
  task automatic samp(input logic [23:0] a, b, c);
    @(negedge clk);
    sample_v = {c, b, a};
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic res_ok;
    res_temp = 24'h000800;
    res_freq = 24'h3c0000;
    res_vrms = {3{24'h400000}};
    res_irms = {3{24'h100000}};
    res_pf = {3{24'h300000}};
  endtask
  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {failures, samples_checked} = '0;
    {rstn, pwr_down, reg_wr, interval_end, energy_valid} = '0;
    {sample_valid, reg_addr, reg_wdata, sample_v, gp_out, gp_oe} = '0;
    energy_in = 48'h000000_c00000;
    res_base = 24'h000100;
    res_ok();
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    rc(8'hff, 24'h0, "unmapped");
    rc(ebms_pkg::A_MAX_BLK, 24'h0, "max slot 0 at reset");
    wr(ebms_pkg::A_BKT_L, 24'h5bf722);
    rc(ebms_pkg::A_BKT_L, 24'h5bf722, "bucket frac");
    wr(ebms_pkg::A_BKT_H, 24'h000001);
    wr(ebms_pkg::A_BKT_L, 24'h800000);
    repeat (3) en();
    rc(ebms_pkg::A_ECNT, 24'h000001, "energy count");
    en();
    rc(ebms_pkg::A_ECNT, 24'h000002, "energy count");
    wr(ebms_pkg::A_SEL0, 24'h000040);
    wr(ebms_pkg::A_SEL0 + 8'h01, 24'h000041);
    ie();
    res_base = 24'h000200;
    ie();
    res_base = 24'h000180;
    ie();
    rc(ebms_pkg::A_MIN_BLK, 24'h000140, "min slot 0");
    rc(ebms_pkg::A_MAX_BLK, 24'h000240, "max slot 0");
    rc(ebms_pkg::A_MIN_BLK + 8'h01, 24'h000141, "min slot 1");
    rc(ebms_pkg::A_MAX_BLK + 8'h02, 24'h0, "max slot 2");
    wr(ebms_pkg::A_CMD, 24'h000001);
    rc(ebms_pkg::A_MAX_BLK, 24'h0, "max slot 0 cleared");
    res_base = 24'h000300;
    ie();
    rc(ebms_pkg::A_MIN_BLK, 24'h000340, "min slot 0 reload");
    @(negedge clk);
    pwr_down = 1'b1;
    @(negedge clk);
    pwr_down = 1'b0;
    rc(ebms_pkg::A_MAX_BLK, 24'h0, "max slot 0 power down");
    rc(ebms_pkg::A_ECNT, 24'h0, "energy power down");
    for (int i = 0; i < 8; i++) wr(ebms_pkg::A_T_MAX + 8'(i), lim[i]);
    ie();
    rc(ebms_pkg::A_STAT, 24'h0, "status in range");
    res_temp = 24'h002000;
    res_freq = 24'h200000;
    res_vrms = {24'h400000, 24'h700000, 24'h080000};
    res_irms[0] = 24'h600000;
    res_pf[1] = 24'h100000;
    rc(ebms_pkg::A_STAT, 24'h0, "status before interval");
    ie();
    rc(ebms_pkg::A_STAT, 24'h312880, "status alarms");
    pin(1'b1);
    wr(ebms_pkg::A_MASK, 24'h000080);
    pin(1'b0);
    res_ok();
    ie();
    rc(ebms_pkg::A_STAT, 24'h0, "status cleared");
    pin(1'b1);
    gp_oe = 3'b111;
    gp_out = 3'b010;
    wr(ebms_pkg::A_CFG, 24'h000005);
    samp(24'hfff000, HI, 24'hfff000);
    samp(HI, HI, HI);
    samp(HI, HI, HI);
    check("sign pins", {21'h0, dio_o}, 24'h000007);
    samp(HI, HI, HI);
    check("sign pins", {21'h0, dio_o}, 24'h000002);
    check("pin enables", {21'h0, dio_oe}, 24'h000007);
    wr(ebms_pkg::A_CFG, 24'h0);
    gp_out = 3'b101;
    repeat (2) @(negedge clk);
    check("gp pins", {21'h0, dio_o}, 24'h000005);
    wr(ebms_pkg::A_MASK, 24'h000010);
    wr(ebms_pkg::A_SAG_LIM, 24'h000100);
    wr(ebms_pkg::A_SAG_CNT, 24'h000004);
    repeat (4) samp(LO, HI, 24'hfffe00);
    rc(ebms_pkg::A_STAT, 24'h000010, "sag set");
    pin(1'b0);
    repeat (4) samp(HI, HI, HI);
    rc(ebms_pkg::A_STAT, 24'h0, "sag released");
    pin(1'b1);
    wr(ebms_pkg::A_STICKY, 24'h000010);
    repeat (4) samp(LO, HI, HI);
    repeat (4) samp(HI, HI, HI);
    rc(ebms_pkg::A_STAT, 24'h000010, "sag held");
    pin(1'b0);
    wr(ebms_pkg::A_SCLR, 24'h000010);
    rc(ebms_pkg::A_STAT, 24'h0, "sag host clear");
    pin(1'b1);
    end_of_test();
  end
endmodule // energy_bucket_minmax_sag_alarms_bench
